// file: pkg/fdms_map.svh
`ifndef FDMS_MAP_SVH
`define FDMS_MAP_SVH

// Register indices; the byte address is four times the index.
`define FDMS_IDX_MEDIA 6'h03
`define FDMS_IDX_STATUS 6'h04
`define FDMS_IDX_CTRL 6'h08
`define FDMS_IDX_DRVID 6'h09

// Control register fields.
`define FDMS_CTRL_ENH_BIT 0
`define FDMS_CTRL_FOUR_BIT 1
`define FDMS_CTRL_SEL_LSB 2

// Media register fields.
`define FDMS_MEDIA_TAPE_LSB 0
`define FDMS_MEDIA_EXCH_LSB 2
`define FDMS_MEDIA_ID_LSB 4

// Reset and fixed values.
`define FDMS_STATUS_NOT_INIT 8'h00
`define FDMS_ID_RESET 2'h3
`define FDMS_DRVID_RESET 8'h00

// AXI responses.
`define FDMS_RESP_OKAY 2'h0
`define FDMS_RESP_SLVERR 2'h2
`define FDMS_RESP_DECERR 2'h3

// Timing: controller initialisation time and the ready deadline.
`define FDMS_CLK_PERIOD_NS 8
`define FDMS_INIT_TIME_NS 1000
`define FDMS_INIT_CYCLES ((`FDMS_INIT_TIME_NS + `FDMS_CLK_PERIOD_NS - 1) / `FDMS_CLK_PERIOD_NS)
`define FDMS_READY_LIMIT_US 2500
`define FDMS_READY_LIMIT_CYCLES ((`FDMS_READY_LIMIT_US * 1000) / `FDMS_CLK_PERIOD_NS)

`endif

// file: pkg/fdms_pkg.sv
package fdms_pkg;

  // AXI4-Lite request channels from the master.
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } fdms_axi_req_t;

  // AXI4-Lite answer channels to the master.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fdms_axi_rsp_t;

  // Events and levels reported by the command engine.
  typedef struct packed {
    logic seekIssued;
    logic [1:0] seekDrive;
    logic senseResultRd;
    logic [1:0] senseDrive;
    logic cmdFirstWr;
    logic cmdLastWr;
    logic cmdNoResult;
    logic resultLastRd;
    logic execNonDma;
    logic dirToHost;
    logic irq;
    logic byteXfer;
    logic byteReady;
    logic swReset;
    logic powerUp;
  } fdms_engine_t;

  // Whole state of the block.
  typedef struct packed {
    fdms_axi_rsp_t rsp;
    logic awHeld;
    logic [5:0] awIdx;
    logic wHeld;
    logic [7:0] wData;
    logic wLane;
    logic enhanced;
    logic fourDrive;
    logic [1:0] dorSel;
    logic [7:0] driveId;
    logic idLive;
    logic [1:0] tapeSel;
    logic [1:0] exch;
    logic [3:0] busy;
    logic cmdBusy;
    logic transfer_ready_flag;
    logic initDone;
    logic [31:0] initCnt;
    logic [1:0] pinSel;
    logic [3:0] pinMotor;
  } fdms_state_t;

endpackage

// file: core/fdms_media_status.sv
// Function
// - Compatible mode: media bits 7..2 read floated; here they read 0
// - Bits 1,0 pick tape drive, never 0
// - Enhanced bits 3,2 swap drive 0 with 1/2
// - No swap with four drives; 3 never
// - Select 00: ID bits show identity bits 1,0
// - Select 01: ID bits show identity bits 3,2
// - Enhanced bits 7,6 mirror media-sense inputs
// - Status read-only, readable any time, no delay
// - Status reads 00h until initialised
// - Status reads 80h within 2.5 ms
// - Seek or recal sets drive busy flag
// - Sense-interrupt first result read clears busy
// - Command-in-progress set first byte, cleared at end
// - Bit 5 shows non-DMA execution phase
// - Bit 6 gives data transfer direction
// - Ready clears per transfer, resets to 0
// - Non-DMA execution: ready follows interrupt request
// - Output register select steers reported identity
// - Media register at index 03h, read/write
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`include "fdms_map.svh"
`timescale 1ns/1ps
`default_nettype none

module fdms_media_status #(
  parameter int unsigned READY_LIMIT_CYCLES = `FDMS_READY_LIMIT_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire fdms_pkg::fdms_axi_req_t axiReq,
  output fdms_pkg::fdms_axi_rsp_t axiRsp,
  input wire fdms_pkg::fdms_engine_t engine,
  input wire logic mediaSenseLo,
  input wire logic mediaSenseHi,
  input wire logic [3:0] dorMotor,
  output logic [1:0] pinDriveSel,
  output logic [3:0] pinMotor,
  output logic [1:0] tapeDrive
);

  // ****************************************************************
  // Constants
  // ****************************************************************

  // Initialisation never takes longer than the ready deadline allows.
  // The counter is a full word, so any deadline value fits.
  // Status reads 00h while it runs, so a short count keeps software polling short.
  localparam int unsigned INIT_RAW = `FDMS_INIT_CYCLES;
  localparam int unsigned INIT_TARGET =
    (INIT_RAW < READY_LIMIT_CYCLES) ? INIT_RAW : READY_LIMIT_CYCLES;
  localparam logic [31:0] INIT_LAST = 32'(INIT_TARGET - 1);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Maps a logical drive to its physical pin position, and back.
  // The exchange is its own inverse, so one function serves both directions.
  // Code 11 is reserved and is treated as no exchange.
  function automatic logic [1:0] swapDrive(
    input logic [1:0] drive,
    input logic [1:0] exch,
    input logic enh,
    input logic four
  );
    logic [1:0] res;
    res = drive;
    if (enh && !four) begin
      unique case (exch)
        2'h1: begin
          if (drive == 2'h0) begin
            res = 2'h1;
          end else if (drive == 2'h1) begin
            res = 2'h0;
          end
        end
        2'h2: begin
          if (drive == 2'h0) begin
            res = 2'h2;
          end else if (drive == 2'h2) begin
            res = 2'h0;
          end
        end
        default: begin
          res = drive; // Drive 3 is never moved.
        end
      endcase
    end
    return res;
  endfunction

  // Picks the identity bits reported for the active drive.
  // Selects 10 and 11 have no identity field and read the reset pattern 11.
  // Until the identity register is written the field also reads 11.
  function automatic logic [1:0] idBits(
    input logic live,
    input logic [1:0] sel,
    input logic [7:0] ident
  );
    logic [1:0] res;
    res = `FDMS_ID_RESET;
    if (live) begin
      if (sel == 2'h0) begin
        res = ident[1:0];
      end else if (sel == 2'h1) begin
        res = ident[3:2];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************

  // Whole state, its next value, and the combinational views around it.
  fdms_pkg::fdms_state_t s;
  fdms_pkg::fdms_state_t next_s;
  logic [7:0] statusByte;
  logic [7:0] mediaByte;
  logic [31:0] readWord;
  logic [1:0] readResp;
  logic restart;
  logic doWrite;
  logic [3:0] busySet;
  logic [3:0] busyClr;
  logic [3:0] motorSwapped;

  // ****************************************************************
  // Per-drive decode
  // ****************************************************************

  // Set and clear strobes of each drive's busy flag, decoded once per drive.
  // Physical motor pin g takes the enable of the logical drive mapped onto it,
  // so an exchange moves motor and select lines together.
  for (genvar g = 0; g < 4; g++) begin : g_drive
    assign busySet[g] = engine.seekIssued && (engine.seekDrive == 2'(g));
    assign busyClr[g] = engine.senseResultRd && (engine.senseDrive == 2'(g));
    assign motorSwapped[g] = dorMotor[swapDrive(2'(g), s.exch, s.enhanced, s.fourDrive)];
  end

  // ****************************************************************
  // Register views
  // ****************************************************************

  // Status byte is a live view, so a read right after a transfer is current.
  // Until initialisation ends it reads all zero, which software takes as not ready.
  always_comb begin
    if (!s.initDone) begin
      statusByte = `FDMS_STATUS_NOT_INIT;
    end else begin
      statusByte[7] = s.transfer_ready_flag;
      statusByte[6] = engine.dirToHost;
      statusByte[5] = engine.execNonDma;
      statusByte[4] = s.cmdBusy;
      statusByte[3:0] = s.busy;
    end
    // Density bits are the sense pins themselves, never stored, so resets leave them.
    if (s.enhanced) begin
      mediaByte[7] = mediaSenseHi;
      mediaByte[6] = mediaSenseLo;
      mediaByte[5:4] = idBits(s.idLive, s.dorSel, s.driveId);
      mediaByte[3:2] = s.exch;
      mediaByte[1:0] = s.tapeSel;
    end else begin
      mediaByte = {6'h00, s.tapeSel};
    end
  end

  // Read multiplexer with an error answer for unmapped indices.
  // The word is captured at the address handshake, so a status read shows that cycle.
  always_comb begin
    readWord = 32'h0000_0000;
    readResp = `FDMS_RESP_OKAY;
    unique case (axiReq.araddr[7:2])
      `FDMS_IDX_MEDIA: begin
        readWord = {24'h00_0000, mediaByte};
      end
      `FDMS_IDX_STATUS: begin
        readWord = {24'h00_0000, statusByte};
      end
      `FDMS_IDX_CTRL: begin
        readWord = {28'h000_0000, s.dorSel, s.fourDrive, s.enhanced};
      end
      `FDMS_IDX_DRVID: begin
        readWord = {24'h00_0000, s.driveId};
      end
      default: begin
        readResp = `FDMS_RESP_DECERR;
      end
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Any reset or power-up restarts the controller initialisation.
  // Host setup (control, identity, tape, exchange) is kept over software reset and power-up; a hardware reset clears it.
  // A write commits only once the previous response is gone, keeping one write in flight.
  assign restart = engine.swReset || engine.powerUp;
  assign doWrite = s.awHeld && s.wHeld && !s.rsp.bvalid;

  // Bus slave, register writes, status flags and pin steering.
  always_comb begin
    next_s = s;

    // Write address and data are taken in either order.
    // Each ready drops once its half is held and reopens with the response.
    if (axiReq.awvalid && s.rsp.awready) begin
      next_s.awHeld = 1'b1;
      next_s.awIdx = axiReq.awaddr[7:2];
      next_s.rsp.awready = 1'b0;
    end
    if (axiReq.wvalid && s.rsp.wready) begin
      next_s.wHeld = 1'b1;
      next_s.wData = axiReq.wdata[7:0];
      next_s.wLane = axiReq.wstrb[0];
      next_s.rsp.wready = 1'b0;
    end

    // Both halves present: store and answer.
    if (doWrite) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = `FDMS_RESP_OKAY;
      unique case (s.awIdx)
        `FDMS_IDX_MEDIA: begin
          if (s.wLane) begin
            next_s.tapeSel = s.wData[`FDMS_MEDIA_TAPE_LSB +: 2];
            if (s.enhanced) begin
              next_s.exch = s.wData[`FDMS_MEDIA_EXCH_LSB +: 2];
            end
          end
        end
        `FDMS_IDX_STATUS: begin
          next_s.rsp.bresp = `FDMS_RESP_SLVERR;
        end
        `FDMS_IDX_CTRL: begin
          if (s.wLane) begin
            next_s.enhanced = s.wData[`FDMS_CTRL_ENH_BIT];
            next_s.fourDrive = s.wData[`FDMS_CTRL_FOUR_BIT];
            next_s.dorSel = s.wData[`FDMS_CTRL_SEL_LSB +: 2];
          end
        end
        `FDMS_IDX_DRVID: begin
          if (s.wLane) begin
            next_s.driveId = s.wData;
            next_s.idLive = 1'b1;
          end
        end
        default: begin
          next_s.rsp.bresp = `FDMS_RESP_DECERR;
        end
      endcase
    end

    // Write response handshake reopens both write channels.
    if (s.rsp.bvalid && axiReq.bready) begin
      next_s.rsp.bvalid = 1'b0;
      next_s.rsp.awready = 1'b1;
      next_s.rsp.wready = 1'b1;
    end

    // Read: one cycle to the answer, held until taken.
    // The read side is independent of the write side, so both may be under way.
    if (axiReq.arvalid && s.rsp.arready) begin
      next_s.rsp.arready = 1'b0;
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata = readWord;
      next_s.rsp.rresp = readResp;
    end
    if (s.rsp.rvalid && axiReq.rready) begin
      next_s.rsp.rvalid = 1'b0;
      next_s.rsp.arready = 1'b1;
    end

    // Drive busy flags; a set in the clearing cycle wins.
    // Each drive has its own strobes, so flags of different drives never interfere.
    for (int d = 0; d < 4; d++) begin
      if (busyClr[d]) begin
        next_s.busy[d] = 1'b0;
      end
      if (busySet[d]) begin
        next_s.busy[d] = 1'b1;
      end
    end

    // Command in progress flag.
    // A first byte in the same cycle as an end starts the next command.
    if (engine.resultLastRd || (engine.cmdLastWr && engine.cmdNoResult)) begin
      next_s.cmdBusy = 1'b0;
    end
    if (engine.cmdFirstWr) begin
      next_s.cmdBusy = 1'b1;
    end

    // Ready flag after initialisation.
    // During non-DMA execution it follows the interrupt request one cycle late.
    if (s.initDone) begin
      if (engine.execNonDma) begin
        next_s.transfer_ready_flag = engine.irq;
      end else begin
        if (engine.byteXfer) begin
          next_s.transfer_ready_flag = 1'b0;
        end
        if (engine.byteReady) begin
          next_s.transfer_ready_flag = 1'b1;
        end
      end
    end else if (s.initCnt == INIT_LAST) begin
      next_s.initDone = 1'b1;
      next_s.transfer_ready_flag = 1'b1; // Status now reads 80h.
    end else begin
      next_s.initCnt = s.initCnt + 32'h0000_0001;
    end

    // Controller restart clears the status side only.
    // It wins over every flag event in the same cycle.
    if (restart) begin
      next_s.busy = 4'h0;
      next_s.cmdBusy = 1'b0;
      next_s.transfer_ready_flag = 1'b0;
      next_s.initDone = 1'b0;
      next_s.initCnt = 32'h0000_0000;
    end

    // Pin steering of drive select and motors.
    // Select and motor lines move together so a drive is never half exchanged.
    next_s.pinSel = swapDrive(s.dorSel, s.exch, s.enhanced, s.fourDrive);
    next_s.pinMotor = motorSwapped;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  // One register for the whole state; reset loads constants only.
  // Engine restarts go through the next-state logic instead, so the bus side is untouched.
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
      s.driveId <= `FDMS_DRVID_RESET;
      s.idLive <= 1'b0; // Identity bits read 11 after reset.
      s.tapeSel <= 2'h0;
      s.exch <= 2'h0;
      s.transfer_ready_flag <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // All outputs come straight from the state register.
  // Pin steering lags a register write by one cycle, and drives see no glitch between.
  assign axiRsp = s.rsp;
  assign pinDriveSel = s.pinSel;
  assign pinMotor = s.pinMotor;
  assign tapeDrive = s.tapeSel; // 00 means no tape drive.

endmodule

`default_nettype wire

// file: dv/fdms_media_status_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker for the media and status register block.
// ****
module fdms_media_status_checker #(
  parameter int unsigned READY_LIMIT_CYCLES = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire fdms_pkg::fdms_axi_req_t axiReq,
  input wire fdms_pkg::fdms_axi_rsp_t axiRsp,
  input wire fdms_pkg::fdms_engine_t engine,
  input wire logic mediaSenseLo,
  input wire logic mediaSenseHi,
  input wire logic [3:0] dorMotor,
  input wire logic [1:0] pinDriveSel,
  input wire logic [3:0] pinMotor,
  input wire logic [1:0] tapeDrive
);
  localparam int INIT = (READY_LIMIT_CYCLES < 125) ? int'(READY_LIMIT_CYCLES) : 125;
  logic [9:0] sinceInit;
  logic [9:0] next_sinceInit;
  logic stRd;
  logic done;
  // Counts cycles since initialisation last restarted.
  always_comb begin
    next_sinceInit = (sinceInit == 10'h3ff) ? sinceInit : sinceInit + 10'h001;
    if (srst || engine.swReset || engine.powerUp) begin
      next_sinceInit = 10'h000;
    end
  end
  always_ff @(posedge clk) begin
    sinceInit <= next_sinceInit;
  end
  // A status read taken on this edge, and initialisation well over.
  assign stRd = axiReq.arvalid && axiRsp.arready && axiReq.araddr == 8'h10;
  assign done = int'(sinceInit) > INIT + 2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_read_answer;
    axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  property p_status_ro;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
      && axiReq.awaddr == 8'h10 |-> ##[1:3] (axiRsp.bvalid && axiRsp.bresp == 2'h2);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write taken");
  property p_init_zero;
    stRd && int'(sinceInit) + 2 < INIT |=> axiRsp.rdata[7:0] == 8'h00;
  endproperty
  a_init_zero: assert property (p_init_zero) else $error("status not zero in init");
  property p_dir_live;
    stRd && done |=> axiRsp.rdata[6:5] == {$past(engine.dirToHost), $past(engine.execNonDma)};
  endproperty
  a_dir_live: assert property (p_dir_live) else $error("direction or exec bit wrong");
  property p_ready_clear;
    stRd && done && $past(engine.byteXfer) && !$past(engine.byteReady)
      && !engine.execNonDma && !$past(engine.execNonDma) |=> !axiRsp.rdata[7];
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");
  property p_ready_irq;
    stRd && done && engine.execNonDma && $past(engine.execNonDma) && !$past(engine.byteXfer)
      |=> axiRsp.rdata[7] == $past(engine.irq, 2);
  endproperty
  a_ready_irq: assert property (p_ready_irq) else $error("ready not irq");
  property p_drive3_fixed;
    pinMotor[3] |-> $past(dorMotor[3]);
  endproperty
  a_drive3_fixed: assert property (p_drive3_fixed) else $error("motor 3 swapped");
  property p_motor_count;
    $countones(pinMotor) <= $countones($past(dorMotor));
  endproperty
  a_motor_count: assert property (p_motor_count) else $error("motor pins invented");
  c_status_read: cover property (stRd && done);
  c_write_done: cover property (axiRsp.bvalid && axiReq.bready);
  c_exec_read: cover property (stRd && engine.execNonDma);
endmodule
bind fdms_media_status fdms_media_status_checker #(.READY_LIMIT_CYCLES(READY_LIMIT_CYCLES)) chk (
  .clk(clk), .srst(srst), .axiReq(axiReq), .axiRsp(axiRsp), .engine(engine),
  .mediaSenseLo(mediaSenseLo), .mediaSenseHi(mediaSenseHi), .dorMotor(dorMotor),
  .pinDriveSel(pinDriveSel), .pinMotor(pinMotor), .tapeDrive(tapeDrive));
`default_nettype wire

// file: dv/fdms_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Host model: an AXI4-Lite master that polls and writes registers.
// ****
module fdms_host (
  input wire logic clk,
  output var fdms_pkg::fdms_axi_req_t req,
  input wire fdms_pkg::fdms_axi_rsp_t rsp
);
  // The bus starts idle.
  initial req = '0;
  // One write; address and data go out together and each drops when taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  // One read; rready is held until the data arrive.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/test_floppy_media_and_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench for the media and status register block.
// ****
module test_floppy_media_and_status_regs;
  localparam int unsigned LIMIT = 16;
  logic clk = 1'b0;
  logic srst = 1'b1;
  fdms_pkg::fdms_axi_req_t axiReq;
  fdms_pkg::fdms_axi_rsp_t axiRsp;
  fdms_pkg::fdms_engine_t engine = '0;
  fdms_pkg::fdms_engine_t lvl = '0;
  logic mediaSenseLo = 1'b0;
  logic mediaSenseHi = 1'b0;
  logic [3:0] dorMotor = 4'h1;
  logic [1:0] pinDriveSel;
  logic [3:0] pinMotor;
  logic [1:0] tapeDrive;
  int mismatches = 0;
  int checkCount = 0;
  fdms_media_status #(.READY_LIMIT_CYCLES(LIMIT)) dut (.clk(clk), .srst(srst),
    .axiReq(axiReq), .axiRsp(axiRsp), .engine(engine), .mediaSenseLo(mediaSenseLo),
    .mediaSenseHi(mediaSenseHi), .dorMotor(dorMotor), .pinDriveSel(pinDriveSel),
    .pinMotor(pinMotor), .tapeDrive(tapeDrive));
  fdms_host host (.clk(clk), .req(axiReq), .rsp(axiRsp));
  // Clock at 125 MHz.
  always #4 clk = ~clk;
  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    host.wr(a, d, r);
    chk("write resp", 32'h0, {30'h0, r});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk(what, {24'h0, exp}, d);
  endtask
  // Applies one engine event for a cycle on top of the held levels.
  task automatic pulse(input fdms_pkg::fdms_engine_t e);
    engine <= fdms_pkg::fdms_engine_t'(lvl | e);
    @(posedge clk);
    engine <= lvl;
    @(posedge clk);
  endtask
  task automatic t_reset();
    rdc(8'h10, 8'h00, "status in init");
    repeat (LIMIT + 4) @(posedge clk);
    rdc(8'h10, 8'h80, "status ready");
  endtask
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    host.wr(8'h10, 8'hff, r);
    chk("status write resp", 32'h2, {30'h0, r});
    rdc(8'h10, 8'h80, "status kept");
    host.rd(8'h30, d, r);
    chk("unmapped resp", 32'h3, {30'h0, r});
    chk("unmapped data", 32'h0, d);
  endtask
  task automatic t_compat();
    wrr(8'h20, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wrr(8'h0c, 8'hfc | 8'(i));
      rdc(8'h0c, 8'(i), "compat media");
      chk("tape", 32'(i), {30'h0, tapeDrive});
    end
  endtask
  task automatic t_enh();
    wrr(8'h20, 8'h01);
    for (int i = 0; i < 4; i++) begin
      {mediaSenseHi, mediaSenseLo} <= 2'(i);
      rdc(8'h0c, {2'(i), 6'h33}, "sense");
    end
    wrr(8'h24, 8'h09);
    rdc(8'h0c, 8'hd3, "id drive 0");
    wrr(8'h20, 8'h05);
    rdc(8'h0c, 8'he3, "id drive 1");
  endtask
  // Each entry: control, exchange code, expected drive pin, expected motor pins.
  task automatic t_exch();
    logic [15:0] tbl [5] = '{16'h0109, 16'h015a, 16'h01ac, 16'h0389, 16'h01c9};
    dorMotor <= 4'h9;
    foreach (tbl[i]) begin
      wrr(8'h20, tbl[i][15:8]);
      wrr(8'h0c, {4'h0, tbl[i][7:6], 2'b00});
      @(posedge clk);
      chk("drive pin", {30'h0, tbl[i][5:4]}, {30'h0, pinDriveSel});
      chk("motor pins", {28'h0, tbl[i][3:0]}, {28'h0, pinMotor});
    end
  endtask
  task automatic t_flags();
    logic [3:0] busy;
    busy = 4'h0;
    for (int d = 0; d < 4; d++) begin
      pulse('{seekIssued: 1'b1, seekDrive: 2'(d), default: 0});
      busy[d] = 1'b1;
      rdc(8'h10, {4'h8, busy}, "busy set");
    end
    pulse('{senseResultRd: 1'b1, senseDrive: 2'h2, default: 0});
    rdc(8'h10, 8'h8b, "busy cleared");
    pulse('{cmdFirstWr: 1'b1, default: 0});
    pulse('{cmdLastWr: 1'b1, default: 0});
    rdc(8'h10, 8'h9b, "command on");
    pulse('{resultLastRd: 1'b1, default: 0});
    rdc(8'h10, 8'h8b, "command done");
    pulse('{cmdFirstWr: 1'b1, default: 0});
    pulse('{cmdLastWr: 1'b1, cmdNoResult: 1'b1, default: 0});
    rdc(8'h10, 8'h8b, "no result done");
  endtask
  task automatic t_xfer();
    lvl.dirToHost = 1'b1;
    pulse('0);
    rdc(8'h10, 8'hcb, "to host");
    fork
      pulse('{byteXfer: 1'b1, default: 0});
      rdc(8'h10, 8'h4b, "ready cleared");
    join
    pulse('{byteReady: 1'b1, default: 0});
    rdc(8'h10, 8'hcb, "ready again");
    lvl.execNonDma = 1'b1;
    pulse('0);
    rdc(8'h10, 8'h6b, "exec no irq");
    lvl.irq = 1'b1;
    pulse('0);
    rdc(8'h10, 8'heb, "exec irq");
    lvl = '0;
    pulse('0);
  endtask
  // Mid-run hardware reset: setup falls back, identity reads 11, density stays live.
  task automatic t_hwreset();
    wrr(8'h0c, 8'h0b);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk("tape after reset", 32'h0, {30'h0, tapeDrive});
    rdc(8'h10, 8'h00, "status after reset");
    wrr(8'h20, 8'h01);
    rdc(8'h0c, 8'hf0, "media after reset");
  endtask
  // Software reset, then power-up: status drops to 00h and comes back to 80h.
  task automatic t_reinit();
    for (int k = 0; k < 2; k++) begin
      fork
        pulse('{swReset: k == 0, powerUp: k == 1, default: 0});
        rdc(8'h10, 8'h00, "restart");
      join
      repeat (LIMIT + 4) @(posedge clk);
      rdc(8'h10, 8'h80, "ready after restart");
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    $display("unexpected timeout: expected end seen hang");
    stop_test();
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_bus();
    t_compat();
    t_enh();
    t_exch();
    t_flags();
    t_xfer();
    t_hwreset();
    t_reinit();
    stop_test();
  end
endmodule
`default_nettype wire
